// *** bench/otpw_monitor.sv ***
// Link checker for the two-wire wiper interface
`timescale 1ns/1ps
`default_nettype none
module otpw_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sel_pin,
   input wire logic scl,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bits;
   logic [1:0] nbyte;
   logic [7:0] addr;
   logic       in_frame;
   logic       start;
   logic       stop;
   logic       rise;
   logic       addr_ok;

   assign rise    = scl & ~scl_q;
   assign start   = scl & scl_q & sda_q & ~sda;
   assign stop    = scl & scl_q & ~sda_q & sda;
   // Strap only moves while the link idles, so the live level is good enough
   assign addr_ok = (addr[7:1] == {otpw_pkg::ADDR_PREFIX, sel_pin});

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Count eight is the ack slot, its rise wraps the count and bumps the byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bits  <= 4'h0;
         nbyte <= 2'h0;
      end else if (start) begin
         bits  <= 4'h0;
         nbyte <= 2'h0;
      end else if (rise) begin
         bits  <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
         nbyte <= (bits == 4'h8) ? nbyte + 2'h1 : nbyte;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr <= 8'h00;
      end else if (rise && nbyte == 2'h0 && bits < 4'h8) begin
         addr <= {addr[6:0], sda};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         in_frame <= 1'b0;
      end else if (start) begin
         in_frame <= 1'b1;
      end else if (stop) begin
         in_frame <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_dev_edge_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device data moved while clock high");
   a_dev_hold: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
      else $error("device drive too short");
   a_ack_slot: assert property ($rose(sda_dev_oe) && !(addr[0] && nbyte != 2'h0)
      |-> bits == 4'h8)
      else $error("device drove outside the ack slot");
   a_addr_miss: assert property (nbyte == 2'h0 && bits == 4'h8 && !addr_ok
      |-> !sda_dev_oe)
      else $error("device answered a foreign address");
   a_addr_ack: assert property ($fell(scl) && nbyte == 2'h0 && bits == 4'h8 && addr_ok
      && addr[0] |-> ##[0:2] sda_dev_oe)
      else $error("own read address not acknowledged");
   a_nack_slot: assert property ($fell(scl) && addr[0] && nbyte == 2'h1 && bits == 4'h8
      |-> ##[0:2] !sda_dev_oe)
      else $error("device held the master ack slot");
   a_idle_free: assert property (!in_frame |-> !sda_dev_oe)
      else $error("device drove the idle bus");
   a_start_free: assert property (start |-> sda_host_oe && !sda_dev_oe)
      else $error("start not made by the master");
   a_scl_high: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
endmodule
`default_nettype wire

// *** bench/test_otp_wiper_i2c_slave.sv ***
// Bench joining the wiper master and device over one link
`timescale 1ns/1ps
`default_nettype none
module test_otp_wiper_i2c_slave;
   logic       clk_sys = 1'b0;
   logic       rst_n;
   logic       cmd_valid;
   logic       cmd_ready;
   logic       cmd_read;
   logic       cmd_addr_sel;
   logic       cmd_lock;
   logic [5:0] cmd_data;
   logic       rsp_valid;
   logic       rsp_nack;
   logic [7:0] rsp_data;
   logic [5:0] wiper_setting;
   logic       otp_locked;
   logic       wiper_update;
   logic       sel_pin;
   logic [5:0] codes [3] = '{6'h2a, 6'h00, 6'h3f};
   int         errors = 0;
   int         compares = 0;
   int         upd_n = 0;

   otpw_if link ();
   otpw_host u_otpw_host (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
      .cmd_addr_sel(cmd_addr_sel), .cmd_lock(cmd_lock), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data));
   // Select pin moves only while the link idles, so its sync settles in time
   otpw_dev u_otpw_dev (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link.dev),
      .address_select_pin(sel_pin), .wiper_setting(wiper_setting),
      .otp_locked(otp_locked), .wiper_update(wiper_update));
   otpw_monitor u_otpw_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .sel_pin(sel_pin),
      .scl(link.scl), .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
      .sda(link.sda));

   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      if (wiper_update === 1'b1) begin
         upd_n <= upd_n + 1;
      end
   end

   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask

   task automatic chk_nack(input logic exp);
      compares++;
      if (rsp_nack !== exp) fail("ack outcome differs");
   endtask

   task automatic chk_byte(input logic [7:0] exp);
      compares++;
      if (rsp_data !== exp) fail("read byte differs");
   endtask

   task automatic chk_ready(input logic exp);
      compares++;
      if (cmd_ready !== exp) fail("command ready differs");
   endtask

   task automatic chk_dev(input logic [5:0] w, input logic lk, input int n);
      compares++;
      if (wiper_setting !== w || otp_locked !== lk || upd_n != n) fail("device state differs");
   endtask

   // One whole transfer; response sampled mid-cycle since it stands one cycle
   task automatic do_cmd(input logic rd, input logic sel, input logic lk, input logic [5:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cmd_valid    <= 1'b1;
      cmd_read     <= rd;
      cmd_addr_sel <= sel;
      cmd_lock     <= lk;
      cmd_data     <= d;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      @(negedge clk_sys);
      chk_ready(1'b0);
      while (rsp_valid !== 1'b1 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 1000) begin
         fail("no response from master");
         wrap_up();
      end
      chk_ready(1'b1);
   endtask

   initial begin
      rst_n        = 1'b0;
      sel_pin      = 1'b0;
      cmd_valid    = 1'b0;
      cmd_read     = 1'b0;
      cmd_addr_sel = 1'b0;
      cmd_lock     = 1'b0;
      cmd_data     = 6'h00;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk_dev(otpw_pkg::WIPER_MID, 1'b0, 0);
      do_cmd(1'b1, 1'b0, 1'b0, 6'h00);
      chk_byte({otpw_pkg::FUSE_BLANK, otpw_pkg::WIPER_MID});
      for (int i = 0; i < 3; i++) begin
         do_cmd(1'b0, 1'b0, 1'b0, codes[i]);
         chk_nack(1'b0);
         chk_dev(codes[i], 1'b0, i + 1);
      end
      do_cmd(1'b1, 1'b0, 1'b0, 6'h00);
      chk_nack(1'b0);
      chk_byte({otpw_pkg::FUSE_BLANK, 6'h3f});
      do_cmd(1'b0, 1'b1, 1'b0, 6'h11);
      chk_nack(1'b1);
      chk_dev(6'h3f, 1'b0, 3);
      // Strap high: the device now answers only the other address
      @(posedge clk_sys);
      sel_pin <= 1'b1;
      do_cmd(1'b0, 1'b1, 1'b0, 6'h0c);
      chk_nack(1'b0);
      chk_dev(6'h0c, 1'b0, 4);
      do_cmd(1'b0, 1'b0, 1'b0, 6'h11);
      chk_nack(1'b1);
      chk_dev(6'h0c, 1'b0, 4);
      do_cmd(1'b1, 1'b1, 1'b0, 6'h00);
      chk_nack(1'b0);
      chk_byte({otpw_pkg::FUSE_BLANK, 6'h0c});
      @(posedge clk_sys);
      sel_pin <= 1'b0;
      // Lock value carries other instruction bits as zero only
      do_cmd(1'b0, 1'b0, 1'b1, 6'h15);
      chk_nack(1'b0);
      chk_dev(6'h15, 1'b1, 5);
      do_cmd(1'b0, 1'b0, 1'b0, 6'h07);
      chk_nack(1'b1);
      chk_dev(6'h15, 1'b1, 5);
      do_cmd(1'b1, 1'b0, 1'b0, 6'h00);
      chk_byte({otpw_pkg::FUSE_PROGRAMMED, 6'h15});
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk_dev(otpw_pkg::WIPER_MID, 1'b0, 5);
      wrap_up();
   end
endmodule
`default_nettype wire

// *** rtl/otpw_dev.sv ***
// Device end: OTP wiper two-wire slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Wiper resets to midscale before programming
// - Master opens transfers with a start
// - Address byte is prefix, select bit, direction
// - Acknowledge matching address, else stay released
// - Write carries address, instruction, data bytes
// - Nine clocks per byte, MSB first
// - Data changes only while clock low
// - Read data follows address acknowledge directly
// - Read byte holds fuse bits and wiper
// - Master NACKs read byte, then stops
// - Master ends each transfer with stop
// - Each acknowledged data byte updates wiper
// - Further data bytes reuse the instruction
// - New instruction needs a new transfer
// - After locking, accept read addressing only
// - Reads may repeat, returning current data
// - Lock bit set freezes wiper value
// - Select pin makes address unique
module otpw_dev (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   otpw_if.dev             bus,
   input  wire logic       address_select_pin,
   output logic [5:0]      wiper_setting,
   output logic            otp_locked,
   output logic            wiper_update
);

   otpw_pkg::otpw_dev_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] rx_byte;
   logic [7:0] next_rx;
   logic [7:0] tx_byte;
   logic       instr_lock;
   logic       locked_link;
   logic [5:0] wiper_link;
   logic       upd_tog;
   logic       start_tog;
   logic       start_seen;
   logic       stop_tog;
   logic       stop_seen;
   logic       sel_meta;
   logic       sel_sync;
   logic       sda_oe;
   logic       upd_meta;
   logic       upd_sync;
   logic       upd_prev;
   logic       upd_event;
   logic       lock_meta;
   logic       lock_sync;

   function automatic logic addr_match(
      input logic [7:0] b,
      input logic       sel,
      input logic       lk
   );
      logic ok;
      ok = (b[7:2] == otpw_pkg::ADDR_PREFIX) && (b[otpw_pkg::SEL_BIT] == sel);
      addr_match = ok && (b[otpw_pkg::RW_BIT] || !lk);
   endfunction

   assign next_rx = {rx_byte[6:0], bus.sda};

   // start: data falls while clock high
   always_ff @(negedge bus.sda or negedge rst_n) begin
      if (!rst_n) begin
         start_tog <= 1'b0;
      end else if (bus.scl) begin
         start_tog <= ~start_tog;
      end
   end

   // stop: data rises while clock high
   always_ff @(posedge bus.sda or negedge rst_n) begin
      if (!rst_n) begin
         stop_tog <= 1'b0;
      end else if (bus.scl) begin
         stop_tog <= ~stop_tog;
      end
   end

   // select pin synchronised to the link clock
   always_ff @(posedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         sel_meta <= 1'b0;
         sel_sync <= 1'b0;
      end else begin
         sel_meta <= address_select_pin;
         sel_sync <= sel_meta;
      end
   end

   // Frame markers seen at each rising clock
   always_ff @(posedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end else begin
         start_seen <= start_tog;
         stop_seen  <= stop_tog;
      end
   end

   // Receive side: sample on rising clock
   always_ff @(posedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         state       <= otpw_pkg::DEV_IDLE;
         bit_cnt     <= 4'h0;
         rx_byte     <= 8'h00;
         tx_byte     <= 8'h00;
         instr_lock  <= 1'b0;
         locked_link <= 1'b0;
         wiper_link  <= otpw_pkg::WIPER_MID;
         upd_tog     <= 1'b0;
      end else if (start_tog != start_seen) begin
         // first bit of the address byte
         state   <= otpw_pkg::DEV_ADDR;
         bit_cnt <= 4'h1;
         rx_byte <= {7'h00, bus.sda};
      end else if (stop_tog != stop_seen) begin
         state   <= otpw_pkg::DEV_IDLE;
         bit_cnt <= 4'h0;
      end else if (state != otpw_pkg::DEV_IDLE && bit_cnt != otpw_pkg::BYTE_BITS) begin
         rx_byte <= next_rx;
         bit_cnt <= bit_cnt + 4'h1;
      end else begin
         bit_cnt <= 4'h0;
         case (state)
            otpw_pkg::DEV_ADDR: begin
               if (!addr_match(rx_byte, sel_sync, locked_link)) begin
                  state <= otpw_pkg::DEV_IDLE;
               end else if (rx_byte[otpw_pkg::RW_BIT]) begin
                  state   <= otpw_pkg::DEV_READ;
                  // fuse bits both set once locked
                  tx_byte <= {(locked_link ? otpw_pkg::FUSE_PROGRAMMED
                                           : otpw_pkg::FUSE_BLANK), wiper_link};
               end else begin
                  state <= otpw_pkg::DEV_INSTR;
               end
            end
            otpw_pkg::DEV_INSTR: begin
               instr_lock <= rx_byte[otpw_pkg::LOCK_BIT];
               state      <= otpw_pkg::DEV_DATA;
            end
            otpw_pkg::DEV_DATA: begin
               wiper_link <= rx_byte[5:0];
               upd_tog    <= ~upd_tog;
               if (instr_lock) begin
                  locked_link <= 1'b1;
                  state       <= otpw_pkg::DEV_IDLE;
               end else begin
                  state <= otpw_pkg::DEV_DATA;
               end
            end
            otpw_pkg::DEV_READ: begin
               // master ACK asks for the byte again
               if (!bus.sda) begin
                  tx_byte <= {(locked_link ? otpw_pkg::FUSE_PROGRAMMED
                                           : otpw_pkg::FUSE_BLANK), wiper_link};
               end else begin
                  state <= otpw_pkg::DEV_IDLE;
               end
            end
            default: begin
               state <= otpw_pkg::DEV_IDLE;
            end
         endcase
      end
   end

   // drive side: change only on falling clock
   always_ff @(negedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe <= 1'b0;
      end else if (start_tog != start_seen || stop_tog != stop_seen) begin
         // Stale state must not drive into a new frame
         sda_oe <= 1'b0;
      end else if (bit_cnt == otpw_pkg::BYTE_BITS) begin
         case (state)
            otpw_pkg::DEV_ADDR: begin
               sda_oe <= addr_match(rx_byte, sel_sync, locked_link);
            end
            otpw_pkg::DEV_INSTR: begin
               sda_oe <= 1'b1;
            end
            otpw_pkg::DEV_DATA: begin
               sda_oe <= !locked_link;
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end else if (state == otpw_pkg::DEV_READ) begin
         sda_oe <= ~tx_byte[3'(4'h7 - bit_cnt)];
      end else begin
         sda_oe <= 1'b0;
      end
   end

   assign bus.sda_dev_oe = sda_oe;

   // Wiper word is stable when its toggle arrives
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         upd_meta  <= 1'b0;
         upd_sync  <= 1'b0;
         upd_prev  <= 1'b0;
         lock_meta <= 1'b0;
         lock_sync <= 1'b0;
      end else begin
         upd_meta  <= upd_tog;
         upd_sync  <= upd_meta;
         upd_prev  <= upd_sync;
         lock_meta <= locked_link;
         lock_sync <= lock_meta;
      end
   end

   assign upd_event = upd_sync ^ upd_prev;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wiper_setting <= otpw_pkg::WIPER_MID;
         wiper_update  <= 1'b0;
      end else begin
         wiper_update <= upd_event;
         if (upd_event) begin
            wiper_setting <= wiper_link;
         end
      end
   end

   assign otp_locked = lock_sync;

endmodule
`default_nettype wire

// *** rtl/otpw_host.sv ***
// Master end: issues wiper writes and reads over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module otpw_host (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   otpw_if.host            bus,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_read,
   input  wire logic       cmd_addr_sel,
   input  wire logic       cmd_lock,
   input  wire logic [5:0] cmd_data,
   output logic            rsp_valid,
   output logic            rsp_nack,
   output logic [7:0]      rsp_data
);

   otpw_pkg::otpw_host_state_t state;
   logic [2:0] div_cnt;
   logic [1:0] ph;
   logic [3:0] bit_cnt;
   logic [1:0] byte_idx;
   logic [1:0] last_byte;
   logic [7:0] tx_mem [3];
   logic [7:0] rx_byte;
   logic       rd;
   logic       nack;
   logic       scl_r;
   logic       oe_r;
   logic       sda_meta;
   logic       sda_sync;
   logic       tick;
   logic       sending;

   assign tick      = (div_cnt == otpw_pkg::SCL_QTR_LAST);
   assign sending   = !(rd && byte_idx == otpw_pkg::RD_LAST_BYTE);
   assign cmd_ready = (state == otpw_pkg::HOST_IDLE);
   assign bus.scl   = scl_r;
   assign bus.sda_host_oe = oe_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state     <= otpw_pkg::HOST_IDLE;
         div_cnt   <= 3'h0;
         ph        <= 2'h0;
         bit_cnt   <= 4'h0;
         byte_idx  <= 2'h0;
         last_byte <= 2'h0;
         tx_mem    <= '{default: 8'h00};
         rx_byte   <= 8'h00;
         rd        <= 1'b0;
         nack      <= 1'b0;
         scl_r     <= 1'b1;
         oe_r      <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_nack  <= 1'b0;
         rsp_data  <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         div_cnt   <= tick ? 3'h0 : div_cnt + 3'h1;
         if (tick) begin
            ph <= ph + 2'h1;
         end
         case (state)
            otpw_pkg::HOST_IDLE: begin
               if (cmd_valid) begin
                  // each command is a fresh transfer
                  tx_mem[0] <= {otpw_pkg::ADDR_PREFIX, cmd_addr_sel, cmd_read};
                  tx_mem[1] <= {cmd_lock, 7'h00};
                  tx_mem[2] <= {2'h0, cmd_data};
                  rd        <= cmd_read;
                  last_byte <= cmd_read ? otpw_pkg::RD_LAST_BYTE : otpw_pkg::WR_LAST_BYTE;
                  byte_idx  <= 2'h0;
                  bit_cnt   <= 4'h0;
                  nack      <= 1'b0;
                  div_cnt   <= 3'h0;
                  ph        <= 2'h0;
                  state     <= otpw_pkg::HOST_START;
               end
            end
            otpw_pkg::HOST_START: begin
               if (tick && ph == 2'h1) begin
                  oe_r <= 1'b1;
               end else if (tick && ph == 2'h3) begin
                  scl_r <= 1'b0;
                  state <= otpw_pkg::HOST_BIT;
               end
            end
            otpw_pkg::HOST_BIT: begin
               if (tick) begin
                  case (ph)
                     2'h0: begin
                        oe_r <= sending && bit_cnt != otpw_pkg::BYTE_BITS
                                && !tx_mem[byte_idx][3'(4'h7 - bit_cnt)];
                     end
                     2'h1: begin
                        scl_r <= 1'b1;
                     end
                     2'h2: begin
                        if (bit_cnt != otpw_pkg::BYTE_BITS) begin
                           rx_byte <= {rx_byte[6:0], sda_sync};
                        end else if (sending) begin
                           nack <= sda_sync;
                        end
                     end
                     default: begin
                        scl_r <= 1'b0;
                        if (bit_cnt != otpw_pkg::BYTE_BITS) begin
                           bit_cnt <= bit_cnt + 4'h1;
                        end else begin
                           bit_cnt <= 4'h0;
                           // read byte gets no acknowledge, then stop
                           if (nack || byte_idx == last_byte) begin
                              state <= otpw_pkg::HOST_STOP;
                           end else begin
                              byte_idx <= byte_idx + 2'h1;
                           end
                        end
                     end
                  endcase
               end
            end
            otpw_pkg::HOST_STOP: begin
               if (tick) begin
                  case (ph)
                     2'h0: begin
                        oe_r <= 1'b1;
                     end
                     2'h1: begin
                        scl_r <= 1'b1;
                     end
                     2'h3: begin
                        oe_r      <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_nack  <= nack;
                        rsp_data  <= rx_byte;
                        state     <= otpw_pkg::HOST_IDLE;
                     end
                     default: begin
                        oe_r <= 1'b1;
                     end
                  endcase
               end
            end
            default: begin
               state <= otpw_pkg::HOST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** rtl/otpw_if.sv ***
// Two-wire link between the OTP wiper master and the device
`timescale 1ns/1ps
`default_nettype none
interface otpw_if;
   logic scl;
   logic sda_host_oe;
   logic sda_dev_oe;
   logic sda;

   // Open drain with pull-up: any enabled driver pulls low
   assign sda = ~(sda_host_oe | sda_dev_oe);

   modport host (
      output scl,
      output sda_host_oe,
      input  sda
   );

   modport dev (
      input  scl,
      input  sda,
      output sda_dev_oe
   );
endinterface
`default_nettype wire

// *** rtl/otpw_pkg.sv ***
// Shared constants and types for the OTP wiper two-wire link
package otpw_pkg;
   localparam logic [5:0] ADDR_PREFIX    = 6'h16;
   localparam logic [5:0] WIPER_MID      = 6'h20;
   localparam logic [1:0] FUSE_PROGRAMMED = 2'h3;
   localparam logic [1:0] FUSE_BLANK     = 2'h0;
   localparam int         LOCK_BIT       = 7;
   localparam int         RW_BIT         = 0;
   localparam int         SEL_BIT        = 1;
   localparam logic [3:0] BYTE_BITS      = 4'h8;
   localparam int         CLK_PERIOD_NS  = 4;
   localparam int         SCL_PERIOD_NS  = 64;
   localparam int         SCL_QTR_CYC    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam logic [2:0] SCL_QTR_LAST   = 3'(SCL_QTR_CYC - 1);
   localparam logic [1:0] WR_LAST_BYTE   = 2'h2;
   localparam logic [1:0] RD_LAST_BYTE   = 2'h1;

   typedef enum logic [2:0] {
      DEV_IDLE,
      DEV_ADDR,
      DEV_INSTR,
      DEV_DATA,
      DEV_READ
   } otpw_dev_state_t;

   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_START,
      HOST_BIT,
      HOST_STOP
   } otpw_host_state_t;
endpackage
